// *** hdl/kwd_keyed_watchdog_timer.sv ***
// Keyed watchdog timer top: APB slave, control/status, actions
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module kwd_keyed_watchdog_timer #(
	parameter int P_EXP_BIT0 = kwd_pkg::EXP_BIT0,
	parameter int P_EXP_BIT1 = kwd_pkg::EXP_BIT1,
	parameter int P_TEST_EXP = kwd_pkg::TEST_EXP,
	parameter int P_RST_HOLD = kwd_pkg::RST_HOLD_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire kwd_pkg::kwd_apb_req_t i_apb,
	output kwd_pkg::kwd_apb_rsp_t o_apb,
	output logic o_nmi_req,
	output logic o_sys_rst_req,
	output logic o_keep_straps,
	output logic o_irq
);
	import kwd_pkg::*;

	////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_s1;
	logic rst_n;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Declarations
	logic run;
	logic act_rst;
	logic rst_occ;
	logic nmi_occ;
	logic test;
	logic [CNT_W-1:0] cnt_field;
	logic cfg_done;
	logic timeout;
	logic nmi_fire;
	logic wdt_fire;
	logic acc;
	logic done;
	logic wr_ev;
	logic rd_ev;
	logic hit_wdt;
	logic hit_stat;
	logic hit_clr;
	logic hit_en;
	logic mapped;
	logic wdt_wr;
	logic wdt_rd;
	logic k_restart;
	logic k_cfg_wr;
	logic k_keyed_wr;
	logic k_keyed_rd;
	logic [15:0] wdt_view;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] next_irq_stat;
	logic [31:0] next_rdata;
	logic [7:0] hold_cnt;
	logic [IRQ_W-1:0] next_irq_en;
	logic [7:0] rst_len;

	////////////////////////////////////////////////////////////////
	// APB decode
	assign acc = i_apb.psel && i_apb.penable;
	assign done = acc && o_apb.pready;
	assign wr_ev = done && i_apb.pwrite;
	assign rd_ev = done && !i_apb.pwrite;
	assign hit_wdt = i_apb.paddr == kwd_byte_addr(IDX_WDT);
	assign hit_stat = i_apb.paddr == kwd_byte_addr(IDX_IRQ_STAT);
	assign hit_clr = i_apb.paddr == kwd_byte_addr(IDX_IRQ_CLR);
	assign hit_en = i_apb.paddr == kwd_byte_addr(IDX_IRQ_EN);
	assign mapped = hit_wdt || hit_stat || hit_clr || hit_en;
	assign wdt_wr = wr_ev && hit_wdt;
	assign wdt_rd = rd_ev && hit_wdt;

	// Count value deliberately absent from the view
	assign wdt_view = {run, act_rst, rst_occ, nmi_occ, test, 3'b000, cnt_field};

	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_wdt) begin
			next_rdata = {16'h0000, wdt_view};
		end else if (hit_stat) begin
			next_rdata = {30'h0000_0000, irq_stat};
		end else if (hit_en) begin
			next_rdata = {30'h0000_0000, irq_en};
		end
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_apb <= '0;
		end else begin
			o_apb.pready <= acc && !o_apb.pready;
			if (acc && !o_apb.pready) begin
				o_apb.pslverr <= !mapped;
				o_apb.prdata <= i_apb.pwrite ? 32'h0000_0000 : next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Key sequences
	kwd_key_tracker u_keys (
		.i_clk(i_mclk),
		.i_rst_n(rst_n),
		.i_flush(wdt_fire),
		.i_wr(wdt_wr),
		.i_rd(wdt_rd),
		.i_wdata(i_apb.pwdata[15:0]),
		.o_restart(k_restart),
		.o_cfg_wr(k_cfg_wr),
		.o_keyed_wr(k_keyed_wr),
		.o_keyed_rd(k_keyed_rd)
	);

	////////////////////////////////////////////////////////////////
	// Counter
	kwd_wd_counter #(
		.EXP0(P_EXP_BIT0),
		.EXP1(P_EXP_BIT1),
		.TEXP(P_TEST_EXP)
	) u_cnt (
		.i_clk(i_mclk),
		.i_rst_n(rst_n),
		.i_run(run),
		.i_restart(k_restart || wdt_fire),
		.i_test(test),
		.i_field(cnt_field),
		.o_timeout(timeout)
	);

	////////////////////////////////////////////////////////////////
	// Timeout action
	assign wdt_fire = timeout && (act_rst || nmi_occ);
	assign nmi_fire = timeout && !act_rst && !nmi_occ;

	// Configuration, one write per reset
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			run <= WDT_RST_VAL[BIT_RUN];
			act_rst <= WDT_RST_VAL[BIT_ACT_RST];
			test <= WDT_RST_VAL[BIT_TEST];
			cnt_field <= CNT_RST_VAL;
			cfg_done <= 1'b0;
		end else if (wdt_fire) begin
			run <= WDT_RST_VAL[BIT_RUN];
			act_rst <= WDT_RST_VAL[BIT_ACT_RST];
			test <= WDT_RST_VAL[BIT_TEST];
			cnt_field <= CNT_RST_VAL;
			cfg_done <= 1'b0;
		end else if (k_cfg_wr && !cfg_done) begin
			run <= i_apb.pwdata[BIT_RUN];
			act_rst <= i_apb.pwdata[BIT_ACT_RST];
			test <= i_apb.pwdata[BIT_TEST];
			cnt_field <= i_apb.pwdata[CNT_W-1:0];
			cfg_done <= 1'b1;
		end
	end

	// Reset-occurred flag survives its own watchdog reset
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_occ <= WDT_RST_VAL[BIT_RST_OCC];
		end else if (wdt_fire) begin
			rst_occ <= 1'b1;
		end else if (k_keyed_wr || k_keyed_rd) begin
			rst_occ <= 1'b0;
		end
	end

	// Set wins over a keyed clear in the same cycle
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_occ <= WDT_RST_VAL[BIT_NMI_OCC];
		end else if (wdt_fire) begin
			nmi_occ <= 1'b0;
		end else if (nmi_fire) begin
			nmi_occ <= 1'b1;
		end else if (k_keyed_wr) begin
			nmi_occ <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_nmi_req <= 1'b0;
		end else begin
			o_nmi_req <= nmi_fire;
		end
	end

	// System reset request held for a fixed number of cycles
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= 8'h00;
			o_sys_rst_req <= 1'b0;
		end else if (wdt_fire) begin
			hold_cnt <= 8'(P_RST_HOLD - 1);
			o_sys_rst_req <= 1'b1;
		end else if (hold_cnt != 8'h00) begin
			hold_cnt <= hold_cnt - 8'h01;
		end else begin
			o_sys_rst_req <= 1'b0;
		end
	end

	// Straps stay latched until an external reset
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_keep_straps <= 1'b0;
		end else if (wdt_fire) begin
			o_keep_straps <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status, clear and enable
	assign irq_set = {wdt_fire, nmi_fire};

	always_comb begin
		next_irq_stat = irq_stat;
		if (wr_ev && hit_clr) begin
			next_irq_stat = irq_stat & ~i_apb.pwdata[IRQ_W-1:0];
		end
		next_irq_stat = next_irq_stat | irq_set;
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= next_irq_stat;
		end
	end

	always_comb begin
		next_irq_en = irq_en;
		if (wr_ev && hit_en) begin
			next_irq_en = i_apb.pwdata[IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en <= '0;
		end else begin
			irq_en <= next_irq_en;
		end
	end

	// Level follows status and enable with no extra lag
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(next_irq_stat & next_irq_en);
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!rst_n);

	// Cycles the reset request has stood so far
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_len <= 8'h00;
		end else if (o_sys_rst_req) begin
			rst_len <= rst_len + 8'h01;
		end else begin
			rst_len <= 8'h00;
		end
	end

	// Key halves on back-to-back transfers, nothing at the register between
	sequence s_unlock;
		wdt_wr && !wdt_fire && i_apb.pwdata[15:0] == KEY_UNLOCK_A
			##1 (!wdt_wr && !wdt_rd && !wdt_fire) [*3]
			##1 wdt_wr && !wdt_fire && i_apb.pwdata[15:0] == KEY_UNLOCK_B;
	endsequence

	sequence s_restart;
		wdt_wr && !wdt_fire && i_apb.pwdata[15:0] == KEY_RESTART_A
			##1 (!wdt_wr && !wdt_rd && !wdt_fire) [*3]
			##1 wdt_wr && i_apb.pwdata[15:0] == KEY_RESTART_B;
	endsequence

	sequence s_next_write;
		(!wdt_wr && !wdt_rd && !wdt_fire) [*3] ##1 wdt_wr && !wdt_fire;
	endsequence

	chk_reset_value: assert property ($rose(rst_n) |-> wdt_view == WDT_RST_VAL)
		else $error("control register reset value wrong");
	chk_unlock_open: assert property (s_unlock ##1 s_next_write |-> k_cfg_wr)
		else $error("unlock did not open a write");
	chk_single_cfg: assert property (cfg_done && !wdt_fire
		|=> $stable({run, act_rst, test, cnt_field}))
		else $error("second config write took effect");
	chk_nmi_path: assert property (nmi_fire |=> o_nmi_req && nmi_occ && !o_sys_rst_req)
		else $error("nmi timeout misrouted");
	chk_second_tmo: assert property (timeout && nmi_occ |=> o_sys_rst_req && rst_occ)
		else $error("second timeout did not reset");
	chk_rst_flag: assert property (wdt_fire |=> rst_occ && cnt_field == CNT_RST_VAL)
		else $error("watchdog reset state wrong");
	chk_nmi_clear: assert property (k_keyed_wr && !nmi_fire && !wdt_fire |=> !nmi_occ)
		else $error("keyed write left nmi flag");
	chk_rst_hold: assert property (wdt_fire ##1 !wdt_fire [*3] |-> o_sys_rst_req)
		else $error("reset request dropped early");
	chk_straps_kept: assert property (o_keep_straps |=> o_keep_straps)
		else $error("strap hold dropped");
	chk_irq_level: assert property (o_irq == |(irq_stat & irq_en))
		else $error("enabled status without interrupt");

	// Bus timing, flag and key guards
	chk_restart_keys: assert property (s_restart |-> k_restart)
		else $error("restart keys did not restart");
	chk_rst_len: assert property ($fell(o_sys_rst_req) |-> rst_len == 8'(P_RST_HOLD))
		else $error("reset request length wrong");
	chk_keyed_rd_clear: assert property (k_keyed_rd && !wdt_fire |=> !rst_occ)
		else $error("keyed read left reset flag");
	chk_cfg_reopen: assert property (wdt_fire |=> !cfg_done)
		else $error("watchdog reset kept config closed");
	chk_stopped_quiet: assert property (!run |-> !timeout)
		else $error("stopped timer timed out");
	chk_nmi_pulse: assert property (o_nmi_req |=> !o_nmi_req)
		else $error("nmi request longer than one cycle");
	chk_apb_wait: assert property (acc && !o_apb.pready |=> o_apb.pready)
		else $error("ready missing after wait state");
	chk_unmapped_err: assert property (acc && !o_apb.pready && !mapped |=> o_apb.pslverr)
		else $error("unmapped access without error");
endmodule
`default_nettype wire

// *** hdl/kwd_pkg.sv ***
// Constants, types and helpers of the keyed watchdog timer
`default_nettype none
package kwd_pkg;
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_WDT = 10'h0e6;
	localparam logic [9:0] IDX_IRQ_STAT = 10'h0e7;
	localparam logic [9:0] IDX_IRQ_CLR = 10'h0e8;
	localparam logic [9:0] IDX_IRQ_EN = 10'h0e9;
	localparam int BIT_RUN = 15;
	localparam int BIT_ACT_RST = 14;
	localparam int BIT_RST_OCC = 13;
	localparam int BIT_NMI_OCC = 12;
	localparam int BIT_TEST = 11;
	localparam int CNT_W = 8;
	localparam logic [15:0] WDT_RST_VAL = 16'hc080;
	localparam logic [7:0] CNT_RST_VAL = 8'h80;
	localparam logic [15:0] KEY_UNLOCK_A = 16'h3333;
	localparam logic [15:0] KEY_UNLOCK_B = 16'hcccc;
	localparam logic [15:0] KEY_RESTART_A = 16'haaaa;
	localparam logic [15:0] KEY_RESTART_B = 16'h5555;
	localparam int EXP_BIT0 = 10;
	localparam int EXP_BIT1 = 20;
	localparam int TEST_EXP = 6;
	localparam int RST_HOLD_CYC = 16;
	localparam int IRQ_NMI = 0;
	localparam int IRQ_RST = 1;
	localparam int IRQ_W = 2;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} kwd_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} kwd_apb_rsp_t;

	typedef enum logic [1:0] {KS_IDLE, KS_UNLK, KS_OPEN, KS_RSTK} kwd_key_state_t;

	function automatic logic [ADDR_W-1:0] kwd_byte_addr(input logic [9:0] idx);
		kwd_byte_addr = {idx, 2'b00};
	endfunction

	// Lowest set bit of the count field wins
	function automatic logic [5:0] kwd_exp_sel(input logic [CNT_W-1:0] f, input int e0,
			input int e1);
		kwd_exp_sel = 6'h00;
		for (int i = CNT_W - 1; i >= 1; i--) begin
			if (f[i]) begin
				kwd_exp_sel = 6'(e1 + i - 1);
			end
		end
		if (f[0]) begin
			kwd_exp_sel = 6'(e0);
		end
	endfunction
endpackage
`default_nettype wire

// *** hdl/kwd_wd_counter.sv ***
// Watchdog cycle counter with exponent select and test mode
`timescale 1ns/1ps
`default_nettype none
module kwd_wd_counter #(
	parameter int EXP0 = kwd_pkg::EXP_BIT0,
	parameter int EXP1 = kwd_pkg::EXP_BIT1,
	parameter int TEXP = kwd_pkg::TEST_EXP,
	parameter int CW = 28
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_restart,
	input wire logic i_test,
	input wire logic [kwd_pkg::CNT_W-1:0] i_field,
	output logic o_timeout
);
	import kwd_pkg::*;
	logic [CW-1:0] cnt;
	logic [CW-1:0] lim;
	logic [5:0] expo;
	logic valid;

	assign valid = |i_field;
	assign expo = i_test ? 6'(TEXP) : kwd_exp_sel(i_field, EXP0, EXP1);
	assign lim = (CW'(1) << expo) - CW'(1);
	// A shrunken period times out at once
	assign o_timeout = i_run && valid && (cnt >= lim);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= '0;
		end else if (i_restart || o_timeout) begin
			cnt <= '0;
		end else if (i_run && valid) begin
			cnt <= cnt + CW'(1);
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_stop_holds: assert property (!i_run && !i_restart |=> $stable(cnt))
		else $error("count moved while stopped");
	chk_restart_zero: assert property (i_restart |=> cnt == '0)
		else $error("restart did not clear count");
	chk_bit0_short: assert property (i_field[0] && !i_test |-> expo == 6'(EXP0))
		else $error("bit 0 did not select shortest");
endmodule
`default_nettype wire

// *** hdl/kwd_key_tracker.sv ***
// Keyed write sequence tracker for the control/status register
`timescale 1ns/1ps
`default_nettype none
module kwd_key_tracker (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_wdata,
	output logic o_restart,
	output logic o_cfg_wr,
	output logic o_keyed_wr,
	output logic o_keyed_rd
);
	import kwd_pkg::*;
	kwd_key_state_t state;
	kwd_key_state_t next_state;

	assign o_restart = i_wr && state == KS_RSTK && i_wdata == KEY_RESTART_B;
	assign o_cfg_wr = i_wr && state == KS_OPEN;
	assign o_keyed_wr = o_cfg_wr || o_restart;
	assign o_keyed_rd = i_rd && state == KS_OPEN;

	always_comb begin
		next_state = state;
		if (i_rd || o_cfg_wr || o_restart) begin
			next_state = KS_IDLE;
		end else if (i_wr) begin
			case (i_wdata)
				KEY_UNLOCK_A: next_state = KS_UNLK;
				KEY_RESTART_A: next_state = KS_RSTK;
				KEY_UNLOCK_B: next_state = (state == KS_UNLK) ? KS_OPEN : KS_IDLE;
				default: next_state = KS_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= KS_IDLE;
		end else if (i_flush) begin
			state <= KS_IDLE;
		end else begin
			state <= next_state;
		end
	end

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_key_abandon: assert property (i_wr && !i_flush && state == KS_UNLK
		&& i_wdata != KEY_UNLOCK_B && i_wdata != KEY_UNLOCK_A && i_wdata != KEY_RESTART_A
		|=> state == KS_IDLE)
		else $error("bad key word kept sequence");
	chk_key_idle_hold: assert property (!i_wr && !i_rd && !i_flush |=> $stable(state))
		else $error("key progress lost without access");
endmodule
`default_nettype wire

// *** tb/kwd_keyed_watchdog_timer_tb_top.sv ***
// Self-checking testbench of the keyed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module kwd_keyed_watchdog_timer_tb_top;
	import kwd_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	kwd_apb_req_t req = '0;
	kwd_apb_rsp_t rsp;
	logic nmi;
	logic srst;
	logic keep;
	logic irq;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	int nmi_seen = 0;
	int rst_seen = 0;
	int nmi_at = 0;
	int rst_at = 0;
	int t0 = 0;
	logic rst_q = 1'b0;
	logic [31:0] rd;
	logic er;

	always #5 i_mclk = ~i_mclk;

	kwd_keyed_watchdog_timer #(
		.P_EXP_BIT0(4),
		.P_EXP_BIT1(6),
		.P_TEST_EXP(3),
		.P_RST_HOLD(4)
	) kwd_keyed_watchdog_timer_inst (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_apb(req),
		.o_apb(rsp),
		.o_nmi_req(nmi),
		.o_sys_rst_req(srst),
		.o_keep_straps(keep),
		.o_irq(irq)
	);

	////////////////////////////////////////////////////////////////////////
	// Event monitor, away from the sampling edge
	always @(negedge i_mclk) begin
		cyc++;
		if (nmi === 1'b1) begin
			nmi_seen++;
			nmi_at = cyc;
		end
		if (srst === 1'b1 && rst_q !== 1'b1) begin
			rst_seen++;
			rst_at = cyc;
		end
		rst_q = srst;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
		@(posedge i_mclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= {idx, 2'b00};
		req.pwdata <= {16'h0000, d};
		@(posedge i_mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge i_mclk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 16'h0000);
		chk(rd, exp);
	endtask

	task automatic keys(input logic [15:0] a, input logic [15:0] b);
		wr(IDX_WDT, a);
		wr(IDX_WDT, b);
	endtask

	task automatic wait_evt(ref int c, input int lim);
		int c0;
		int n;
		c0 = c;
		n = 0;
		while (c == c0 && n < lim) begin
			@(posedge i_mclk);
			n++;
		end
		chk(32'(c - c0), 32'd1);
	endtask

	task automatic win(input int d, input int lo, input int hi);
		chk(32'(d >= lo && d <= hi), 32'd1);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic sc_reset_values();
		rdc(IDX_WDT, 32'h0000c080);
		apb(1'b0, 10'h0f0, 16'h0000);
		chk(rd, 32'h00000000);
		chk({31'h0, er}, 32'h00000001);
		wr(IDX_IRQ_EN, 16'h0003);
		rdc(IDX_IRQ_EN, 32'h00000003);
	endtask

	task automatic sc_config_once();
		wr(IDX_WDT, KEY_UNLOCK_A);
		wr(IDX_WDT, 16'h1234);
		keys(KEY_UNLOCK_B, 16'h8006);
		rdc(IDX_WDT, 32'h0000c080);
		keys(KEY_RESTART_A, KEY_RESTART_B);
		wr(IDX_WDT, KEY_UNLOCK_A);
		rdc(IDX_IRQ_STAT, 32'h00000000);
		keys(KEY_UNLOCK_B, 16'h8006);
		rdc(IDX_WDT, 32'h00008006);
		keys(KEY_UNLOCK_A, KEY_UNLOCK_B);
		wr(IDX_WDT, 16'h4080);
		rdc(IDX_WDT, 32'h00008006);
	endtask

	task automatic sc_nmi();
		keys(KEY_RESTART_A, KEY_RESTART_B);
		t0 = cyc;
		wait_evt(nmi_seen, 100);
		win(nmi_at - t0, 60, 70);
		rdc(IDX_WDT, 32'h00009006);
		rdc(IDX_IRQ_STAT, 32'h00000001);
		chk({31'h0, irq}, 32'h00000001);
		wr(IDX_IRQ_EN, 16'h0000);
		repeat (2) @(posedge i_mclk);
		chk({31'h0, irq}, 32'h00000000);
		wr(IDX_IRQ_EN, 16'h0003);
		wr(IDX_IRQ_CLR, 16'h0001);
		repeat (2) @(posedge i_mclk);
		chk({31'h0, irq}, 32'h00000000);
		rdc(IDX_IRQ_STAT, 32'h00000000);
		keys(KEY_RESTART_A, KEY_RESTART_B);
		rdc(IDX_WDT, 32'h00008006);
	endtask

	task automatic sc_escalate();
		wait_evt(nmi_seen, 100);
		t0 = nmi_at;
		wait_evt(rst_seen, 100);
		win(rst_at - t0, 60, 70);
		chk({31'h0, keep}, 32'h00000001);
		repeat (8) @(posedge i_mclk);
		rdc(IDX_WDT, 32'h0000e080);
		rdc(IDX_IRQ_STAT, 32'h00000003);
	endtask

	task automatic sc_flags_test();
		keys(KEY_UNLOCK_A, KEY_UNLOCK_B);
		apb(1'b0, IDX_WDT, 16'h0000);
		rdc(IDX_WDT, 32'h0000c080);
		keys(KEY_UNLOCK_A, KEY_UNLOCK_B);
		wr(IDX_WDT, 16'hc880);
		t0 = cyc;
		wait_evt(rst_seen, 20);
		win(rst_at - t0, 0, 14);
		repeat (8) @(posedge i_mclk);
		keys(KEY_UNLOCK_A, KEY_UNLOCK_B);
		wr(IDX_WDT, 16'h0002);
		rdc(IDX_WDT, 32'h00000002);
		t0 = nmi_seen + rst_seen;
		repeat (300) @(posedge i_mclk);
		chk(32'(nmi_seen + rst_seen - t0), 32'h00000000);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_mclk);
		sc_reset_values();
		sc_config_once();
		sc_nmi();
		sc_escalate();
		sc_flags_test();
		wrap_up();
	end

	// Cuts a hang short
	initial begin
		repeat (5000) @(posedge i_mclk);
		fail_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
